/* hw/igmdc_pkg.sv */
// Constants and types shared by the input gain, mute and offset filter block.
// Assumes a 32-bit classic Wishbone bus with byte addresses, one register per word.
package igmdc_pkg;

  // ******************************************************************
  // Bus and register map
  // ******************************************************************
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned IDX_W = ADR_W - 2;

  localparam logic [IDX_W-1:0] IDX_LEFT_INPUT   = 6'h00;
  localparam logic [IDX_W-1:0] IDX_RIGHT_INPUT  = 6'h01;
  localparam logic [IDX_W-1:0] IDX_AUDIO_PATH   = 6'h05;
  localparam logic [IDX_W-1:0] IDX_RATE_SELECT  = 6'h08;
  localparam logic [IDX_W-1:0] IDX_LEFT_OFFSET  = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_RIGHT_OFFSET = 6'h0b;

  // ******************************************************************
  // Field layout
  // ******************************************************************
  localparam int unsigned GAIN_W       = 5;
  localparam int unsigned GAIN_LSB     = 0;
  localparam int unsigned SILENCE_BIT  = 7;
  localparam int unsigned SHARED_BIT   = 8;
  localparam int unsigned HPD_BIT      = 0;
  localparam int unsigned HOLD_BIT     = 4;
  localparam int unsigned RATE_W       = 2;
  localparam int unsigned RATE_LSB     = 0;
  localparam int unsigned SEL_LOW_LANE = 0;
  localparam int unsigned SEL_HI_LANE  = 1;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [GAIN_W-1:0] GAIN_RESET    = 5'h17;
  localparam logic              SILENCE_RESET = 1'b1;
  localparam logic              HPD_RESET     = 1'b0;
  localparam logic              HOLD_RESET    = 1'b0;
  localparam logic [RATE_W-1:0] RATE_RESET    = 2'h0;

  // ******************************************************************
  // Sample path
  // ******************************************************************
  localparam int unsigned SAMPLE_W   = 24;
  localparam int unsigned MAX_SHIFT  = 3;
  localparam int unsigned ACC_W      = SAMPLE_W + MAX_SHIFT;
  localparam int unsigned CNT_W      = MAX_SHIFT;
  localparam int unsigned HP_SHIFT   = 8;
  localparam int unsigned NUM_CH     = 2;
  localparam int unsigned FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    IGMDC_FILT_PASS,
    IGMDC_FILT_HALF,
    IGMDC_FILT_QUARTER,
    IGMDC_FILT_EIGHTH
  } igmdc_filter_type;

endpackage : igmdc_pkg

/* hw/igmdc_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module igmdc_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // Fill side.
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [PTR_W:0]              count;
  } igmdc_fifo_state_type;

  igmdc_fifo_state_type s_reg;
  igmdc_fifo_state_type s_next;
  logic                 push;
  logic                 pop;

  assign in_ready_o  = (s_reg.count != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (s_reg.count != '0);
  assign out_data_o  = s_reg.mem[s_reg.rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr_ptr] = in_data_i;
      s_next.wr_ptr            = (s_reg.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : s_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_next.rd_ptr = (s_reg.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : s_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : igmdc_fifo

/* hw/igmdc_top.sv */
// Stereo line-input control: gain and silence settings, decimation and DC offset removal.
// Assumes a classic Wishbone master and a modulator source delivering both channels together.
//
// Notes on behaviour
// - Right gain is five bits; 11111 is +12 dB, 1.5 dB per code down.
// - Right silence bit 7 mutes the right input; it is set after reset.
// - Right write with bit 8 set loads the same gain and silence into left.
// - Left write with shared-load bit set copies left gain and silence into right.
// - Audio path bit 0 disables the high-pass stage; reset value 0 enables it.
// - While enabled, the offset estimate keeps updating and is subtracted from samples.
// - Hold bit 4 set at disable freezes the estimate and keeps subtracting it.
// - While disabled, the held estimate keeps its value until the stage is re-enabled or the hold bit is cleared.
// - Hold bit clear (reset value) clears the estimate when disabled; no correction.
// - Samples are summed at 27 bits while decimating, then cut to 24 bits at the output rate.
// - Both channels always run together; no per-channel enable exists.
// - Decimation filter type follows the chosen sample rate automatically.
// - Left gain uses the same coding and resets to 10111, i.e. 0 dB.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
module igmdc_top (
  // Clock and reset.
  input  wire logic                                  clk_i,
  input  wire logic                                  reset_n_i,
  // Wishbone slave.
  input  wire logic                                  cyc_i,
  input  wire logic                                  stb_i,
  input  wire logic                                  we_i,
  input  wire logic [igmdc_pkg::ADR_W-1:0]           adr_i,
  input  wire logic [igmdc_pkg::SEL_W-1:0]           sel_i,
  input  wire logic [igmdc_pkg::DAT_W-1:0]           dat_i,
  output logic [igmdc_pkg::DAT_W-1:0]                dat_o,
  output logic                                       ack_o,
  // Analogue front-end settings.
  output logic [igmdc_pkg::GAIN_W-1:0]               left_gain_code_o,
  output logic                                       left_silence_o,
  output logic [igmdc_pkg::GAIN_W-1:0]               right_gain_code_o,
  output logic                                       right_silence_o,
  output igmdc_pkg::igmdc_filter_type                filter_type_o,
  // Modulator sample input, both channels per beat.
  input  wire logic                                  in_valid_i,
  output logic                                       in_ready_o,
  input  wire logic [igmdc_pkg::SAMPLE_W-1:0]        in_left_i,
  input  wire logic [igmdc_pkg::SAMPLE_W-1:0]        in_right_i,
  // Decimated, offset-corrected output.
  output logic                                       out_valid_o,
  input  wire logic                                  out_ready_i,
  output logic [igmdc_pkg::SAMPLE_W-1:0]             out_left_o,
  output logic [igmdc_pkg::SAMPLE_W-1:0]             out_right_o
);

  import igmdc_pkg::*;

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    logic                               ack;
    logic [DAT_W-1:0]                   rdata;
    logic [GAIN_W-1:0]                  left_gain;
    logic                               left_silence;
    logic [GAIN_W-1:0]                  right_gain;
    logic                               right_silence;
    logic                               highpass_disable;
    logic                               offset_hold;
    logic [RATE_W-1:0]                  rate;
    logic [CNT_W-1:0]                   dec_count;
    logic [NUM_CH-1:0][ACC_W-1:0]       acc;
    logic [NUM_CH-1:0][SAMPLE_W-1:0]    est;
  } igmdc_state_type;

  igmdc_state_type                  s_reg;
  igmdc_state_type                  s_next;
  logic                             fifo_in_ready;
  logic                             push_valid;
  logic [2*SAMPLE_W-1:0]            push_data;
  logic [2*SAMPLE_W-1:0]            pop_data;
  logic [IDX_W-1:0]                 idx;
  logic                             access;
  logic                             write_now;
  logic                             take;
  logic                             last_beat;

  // ******************************************************************
  // Helper functions
  // ******************************************************************
  // Maps the rate selection onto the decimation filter in use.
  function automatic igmdc_filter_type filter_of(input logic [RATE_W-1:0] rate);
    unique case (rate)
      2'h0:    filter_of = IGMDC_FILT_PASS;
      2'h1:    filter_of = IGMDC_FILT_HALF;
      2'h2:    filter_of = IGMDC_FILT_QUARTER;
      2'h3:    filter_of = IGMDC_FILT_EIGHTH;
    endcase
  endfunction : filter_of

  // Number of input beats per output sample, minus one.
  function automatic logic [CNT_W-1:0] beats_of(input logic [RATE_W-1:0] rate);
    beats_of = CNT_W'((1 << rate) - 1);
  endfunction : beats_of

  // Clamps a 25-bit signed difference into the 24-bit sample range.
  function automatic logic [SAMPLE_W-1:0] sat24(input logic signed [SAMPLE_W:0] v);
    if (v[SAMPLE_W] != v[SAMPLE_W-1]) begin
      sat24 = {v[SAMPLE_W], {(SAMPLE_W-1){~v[SAMPLE_W]}}};
    end else begin
      sat24 = v[SAMPLE_W-1:0];
    end
  endfunction : sat24

  // Sign-extends one channel's stored estimate into a 32-bit read word.
  function automatic logic [DAT_W-1:0] ext32(input logic [SAMPLE_W-1:0] v);
    ext32 = {{(DAT_W-SAMPLE_W){v[SAMPLE_W-1]}}, v};
  endfunction : ext32

  // ******************************************************************
  // Bus decode
  // ******************************************************************
  assign idx       = adr_i[ADR_W-1:2];
  assign access    = cyc_i & stb_i;
  assign write_now = access & we_i & s_reg.ack;

  // ******************************************************************
  // Sample path handshake
  // ******************************************************************
  // Back-pressure from the FIFO stalls the modulator side on every beat.
  assign take       = in_valid_i & fifo_in_ready;
  assign last_beat  = (s_reg.dec_count == beats_of(s_reg.rate));
  assign in_ready_o = fifo_in_ready;
  assign push_valid = take & last_beat;

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    logic [NUM_CH-1:0][SAMPLE_W-1:0]  x;
    logic signed [ACC_W-1:0]          sum;
    logic signed [ACC_W-1:0]          dec;
    logic signed [SAMPLE_W-1:0]       d24;
    logic signed [SAMPLE_W-1:0]       cur_est;
    logic signed [SAMPLE_W:0]         diff;
    logic signed [SAMPLE_W:0]         step;
    x       = {in_right_i, in_left_i};
    sum     = '0;
    dec     = '0;
    d24     = '0;
    cur_est = '0;
    diff    = '0;
    step    = '0;
    s_next    = s_reg;
    push_data = '0;

    // Answer every request one cycle after it appears, then drop ack.
    s_next.ack = access & ~s_reg.ack;
    if (access && !s_reg.ack) begin
      unique case (idx)
        IDX_LEFT_INPUT: begin
          s_next.rdata                                  = '0;
          s_next.rdata[GAIN_LSB +: GAIN_W]              = s_reg.left_gain;
          s_next.rdata[SILENCE_BIT]                     = s_reg.left_silence;
        end
        IDX_RIGHT_INPUT: begin
          s_next.rdata                                  = '0;
          s_next.rdata[GAIN_LSB +: GAIN_W]              = s_reg.right_gain;
          s_next.rdata[SILENCE_BIT]                     = s_reg.right_silence;
        end
        IDX_AUDIO_PATH: begin
          s_next.rdata                                  = '0;
          s_next.rdata[HPD_BIT]                         = s_reg.highpass_disable;
          s_next.rdata[HOLD_BIT]                        = s_reg.offset_hold;
        end
        IDX_RATE_SELECT: begin
          s_next.rdata                                  = '0;
          s_next.rdata[RATE_LSB +: RATE_W]              = s_reg.rate;
        end
        IDX_LEFT_OFFSET:  s_next.rdata = ext32(s_reg.est[0]);
        IDX_RIGHT_OFFSET: s_next.rdata = ext32(s_reg.est[1]);
        default:          s_next.rdata = '0;
      endcase
    end

    // Writes land at the edge that carries ack.
    if (write_now && sel_i[SEL_LOW_LANE]) begin
      unique case (idx)
        IDX_LEFT_INPUT: begin
          s_next.left_gain    = dat_i[GAIN_LSB +: GAIN_W];
          s_next.left_silence = dat_i[SILENCE_BIT];
          if (sel_i[SEL_HI_LANE] && dat_i[SHARED_BIT]) begin
            s_next.right_gain    = dat_i[GAIN_LSB +: GAIN_W];
            s_next.right_silence = dat_i[SILENCE_BIT];
          end
        end
        IDX_RIGHT_INPUT: begin
          s_next.right_gain    = dat_i[GAIN_LSB +: GAIN_W];
          s_next.right_silence = dat_i[SILENCE_BIT];
          if (sel_i[SEL_HI_LANE] && dat_i[SHARED_BIT]) begin
            s_next.left_gain    = dat_i[GAIN_LSB +: GAIN_W];
            s_next.left_silence = dat_i[SILENCE_BIT];
          end
        end
        IDX_AUDIO_PATH: begin
          s_next.highpass_disable = dat_i[HPD_BIT];
          s_next.offset_hold      = dat_i[HOLD_BIT];
        end
        IDX_RATE_SELECT: begin
          s_next.rate = dat_i[RATE_LSB +: RATE_W];
        end
        default: begin
        end
      endcase
    end

    // Decimation: a boxcar over 1, 2, 4 or 8 beats on both channels at once.
    if (take) begin
      s_next.dec_count = last_beat ? '0 : s_reg.dec_count + 1'b1;
    end
    for (int ch = 0; ch < NUM_CH; ch++) begin
      sum     = $signed(s_reg.acc[ch]) + ACC_W'($signed(x[ch]));
      dec     = sum >>> s_reg.rate;
      d24     = dec[SAMPLE_W-1:0];
      cur_est = $signed(s_reg.est[ch]);
      diff    = {d24[SAMPLE_W-1], d24} - {cur_est[SAMPLE_W-1], cur_est};
      step    = diff >>> HP_SHIFT;
      push_data[ch*SAMPLE_W +: SAMPLE_W] = sat24(diff);
      if (take) begin
        s_next.acc[ch] = last_beat ? '0 : sum;
      end
      if (s_reg.highpass_disable) begin
        if (!s_reg.offset_hold) begin
          s_next.est[ch] = '0;
        end
      end else if (push_valid) begin
        s_next.est[ch] = SAMPLE_W'(cur_est + step[SAMPLE_W-1:0]);
      end
    end

    // A new rate restarts accumulation so no output mixes two rates.
    if (write_now && sel_i[SEL_LOW_LANE] && idx == IDX_RATE_SELECT) begin
      s_next.dec_count = '0;
      s_next.acc       = '0;
    end
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_reg                  <= '0;
      s_reg.left_gain        <= GAIN_RESET;
      s_reg.left_silence     <= SILENCE_RESET;
      s_reg.right_gain       <= GAIN_RESET;
      s_reg.right_silence    <= SILENCE_RESET;
      s_reg.highpass_disable <= HPD_RESET;
      s_reg.offset_hold      <= HOLD_RESET;
      s_reg.rate             <= RATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ******************************************************************
  // Output FIFO
  // ******************************************************************
  igmdc_fifo #(
    .WIDTH (2 * SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (pop_data)
  );

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign dat_o             = s_reg.rdata;
  assign ack_o             = s_reg.ack;
  assign left_gain_code_o  = s_reg.left_gain;
  assign left_silence_o    = s_reg.left_silence;
  assign right_gain_code_o = s_reg.right_gain;
  assign right_silence_o   = s_reg.right_silence;
  assign filter_type_o     = filter_of(s_reg.rate);
  assign out_left_o        = pop_data[0 +: SAMPLE_W];
  assign out_right_o       = pop_data[SAMPLE_W +: SAMPLE_W];

endmodule : igmdc_top

/* tb/igmdc_checker.sv */
// Concurrent checks on the ports of igmdc_top.
// Assumes a classic Wishbone master that drops cyc and stb after each ack.
`timescale 1ns/1ns
module igmdc_checker (
  // Clock and reset.
  input wire logic                          clk_i,
  input wire logic                          reset_n_i,
  // Register bus.
  input wire logic                          cyc_i,
  input wire logic                          stb_i,
  input wire logic                          we_i,
  input wire logic [igmdc_pkg::ADR_W-1:0]   adr_i,
  input wire logic [igmdc_pkg::SEL_W-1:0]   sel_i,
  input wire logic [igmdc_pkg::DAT_W-1:0]   dat_i,
  input wire logic                          ack_o,
  // Settings and output stream.
  input wire logic [igmdc_pkg::GAIN_W-1:0]  left_gain_code_o,
  input wire logic                          left_silence_o,
  input wire logic [igmdc_pkg::GAIN_W-1:0]  right_gain_code_o,
  input wire logic                          right_silence_o,
  input wire igmdc_pkg::igmdc_filter_type   filter_type_o,
  input wire logic                          out_valid_o,
  input wire logic                          out_ready_i,
  input wire logic [igmdc_pkg::SAMPLE_W-1:0] out_left_o,
  input wire logic [igmdc_pkg::SAMPLE_W-1:0] out_right_o
);
  import igmdc_pkg::*;
  logic wr_l;
  logic wr_r;
  logic share;
  assign wr_l = ack_o && we_i && sel_i[SEL_LOW_LANE] && adr_i[7:2] == IDX_LEFT_INPUT;
  assign wr_r = ack_o && we_i && sel_i[SEL_LOW_LANE] && adr_i[7:2] == IDX_RIGHT_INPUT;
  assign share = sel_i[SEL_HI_LANE] && dat_i[SHARED_BIT];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_ack_lat;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_r_copy;
    wr_r && share |=> left_gain_code_o == $past(dat_i[4:0]) && left_silence_o == $past(dat_i[7])
      && right_gain_code_o == left_gain_code_o;
  endproperty
  a_r_copy: assert property (p_r_copy) else $error("right to left copy wrong");
  property p_r_only;
    wr_r && !share |=> $stable(left_gain_code_o) && $stable(left_silence_o)
      && right_gain_code_o == $past(dat_i[4:0]);
  endproperty
  a_r_only: assert property (p_r_only) else $error("right write touched left");
  property p_l_copy;
    wr_l && share |=> right_gain_code_o == $past(dat_i[4:0]) && right_silence_o == $past(dat_i[7]);
  endproperty
  a_l_copy: assert property (p_l_copy) else $error("left to right copy wrong");
  property p_r_mute;
    wr_r |=> right_silence_o == $past(dat_i[SILENCE_BIT]);
  endproperty
  a_r_mute: assert property (p_r_mute) else $error("right silence wrong");
  property p_hold;
    !(ack_o && we_i) |=> $stable(left_gain_code_o) && $stable(right_gain_code_o) && $stable(filter_type_o);
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved without write");
  property p_out_stand;
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_left_o) && $stable(out_right_o);
  endproperty
  a_out_stand: assert property (p_out_stand) else $error("output moved while stalled");
  c_share: cover property (wr_r && share);
  c_stall: cover property (out_valid_o && !out_ready_i);
  c_eighth: cover property (filter_type_o == IGMDC_FILT_EIGHTH);
endmodule : igmdc_checker

bind igmdc_top igmdc_checker i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .left_gain_code_o(left_gain_code_o),
  .left_silence_o(left_silence_o), .right_gain_code_o(right_gain_code_o), .right_silence_o(right_silence_o),
  .filter_type_o(filter_type_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .out_left_o(out_left_o), .out_right_o(out_right_o));

/* tb/igmdc_sink_model.sv */
// Sink that drains the output stream, stalling at random.
// Assumes the bench raises stall_i to let the output FIFO fill.
`timescale 1ns/1ns
module igmdc_sink_model (
  // Clock, reset and stall.
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  input  wire logic                            stall_i,
  // Stream from the block.
  input  wire logic                            valid_i,
  output logic                                 ready_o,
  input  wire logic [igmdc_pkg::SAMPLE_W-1:0]  left_i,
  input  wire logic [igmdc_pkg::SAMPLE_W-1:0]  right_i,
  // Beat just taken.
  output logic                                 got_o,
  output logic [igmdc_pkg::SAMPLE_W-1:0]       got_left_o,
  output logic [igmdc_pkg::SAMPLE_W-1:0]       got_right_o
);
  import igmdc_pkg::*;
  initial begin
    ready_o = 1'b0;
    got_o = 1'b0;
  end
  always @(posedge clk_i) begin
    got_o <= reset_n_i && valid_i && ready_o;
    if (valid_i && ready_o) begin
      got_left_o <= left_i;
      got_right_o <= right_i;
    end
    ready_o <= reset_n_i && !stall_i && ($urandom_range(3) != 0);
  end
endmodule : igmdc_sink_model

/* tb/igmdc_top_tb.sv */
// Self-checking bench for the gain, silence and offset filter block.
// Assumes the sink model and the bound checker from this folder.
`timescale 1ns/1ns
module igmdc_top_tb;
  import igmdc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, in_valid_i = 1'b0, stall = 1'b0;
  logic [ADR_W-1:0] adr_i = '0;
  logic [SEL_W-1:0] sel_i = '0;
  logic [DAT_W-1:0] dat_i = '0, dat_o, q, e, e2;
  logic ack_o, left_silence_o, right_silence_o, in_ready_o, out_valid_o, out_ready_i, got, ch, s, b;
  logic [GAIN_W-1:0] left_gain_code_o, right_gain_code_o, g;
  igmdc_filter_type filter_type_o;
  logic [SAMPLE_W-1:0] in_left_i = '0, in_right_i = '0, out_left_o, out_right_o, got_l, got_r, ol, orr, x, y;
  logic [SAMPLE_W-1:0] ql [4], qr [4];
  logic [GAIN_W-1:0] mg [2];
  logic ms [2];
  logic [3:0] sl;
  int num_errors = 0, n_checks = 0, cycles = 0, sa, sb;

  igmdc_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .left_gain_code_o(left_gain_code_o), .left_silence_o(left_silence_o), .right_gain_code_o(right_gain_code_o),
    .right_silence_o(right_silence_o), .filter_type_o(filter_type_o), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .in_left_i(in_left_i), .in_right_i(in_right_i), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_left_o(out_left_o), .out_right_o(out_right_o));
  igmdc_sink_model i_sink (.clk_i(clk_i), .reset_n_i(reset_n_i), .stall_i(stall), .valid_i(out_valid_o),
    .ready_o(out_ready_i), .left_i(out_left_o), .right_i(out_right_o), .got_o(got), .got_left_o(got_l),
    .got_right_o(got_r));

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  // ***************************************************************
  // Bus, stream and report tasks
  // ***************************************************************
  task check(input string nm, input logic [2*SAMPLE_W-1:0] ex, input logic [2*SAMPLE_W-1:0] sn);
    n_checks++;
    if (sn !== ex) begin
      $display("ERROR %s expected %h seen %h", nm, ex, sn);
      num_errors++;
    end
  endtask : check
  task results;
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task wb(input logic w, input logic [7:0] a, input logic [3:0] se, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= se; dat_i <= d;
    do begin @(posedge clk_i); end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    #1;
  endtask : wb
  task push(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
    @(posedge clk_i);
    in_valid_i <= 1'b1; in_left_i <= l; in_right_i <= r;
    do begin @(posedge clk_i); end while (in_ready_o !== 1'b1);
    in_valid_i <= 1'b0;
  endtask : push
  task pull;
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (got !== 1'b1 && n < 60);
    check("output beat", 1, got);
    ol = got_l;
    orr = got_r;
  endtask : pull

  initial begin
    q = $urandom(51501);
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    check("left gain", GAIN_RESET, left_gain_code_o);
    check("right silence", 1, right_silence_o);
    wb(0, 8'h00, 4'hf, 0); check("left reg", 32'h97, q);
    wb(0, 8'h04, 4'hf, 0); check("right reg", 32'h97, q);
    wb(0, 8'h14, 4'hf, 0); check("path reg", 0, q);
    wb(0, 8'hfc, 4'hf, 0); check("unmapped", 0, q);
    mg[0] = GAIN_RESET; mg[1] = GAIN_RESET; ms[0] = 1; ms[1] = 1;
    for (int i = 0; i < 20; i++) begin
      ch = $urandom_range(1); s = $urandom; b = $urandom; g = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : $urandom;
      sl = (i < 4) ? 4'hf : ($urandom_range(2) == 0) ? 4'h1 : ($urandom_range(1) ? 4'h2 : 4'hf);
      wb(1, {5'h0, ch, 2'b00}, sl, {23'h0, b, s, 2'b00, g});
      if (sl[0]) begin
        mg[ch] = g; ms[ch] = s;
        if (b && sl[1]) begin mg[!ch] = g; ms[!ch] = s; end
      end
      check("left gain", mg[0], left_gain_code_o);
      check("right gain", mg[1], right_gain_code_o);
      check("left silence", ms[0], left_silence_o);
      check("right silence", ms[1], right_silence_o);
      wb(0, {5'h0, ch, 2'b00}, 4'hf, 0); check("gain reg", {ms[ch], 2'b00, mg[ch]}, q);
    end
    wb(1, 8'h14, 4'hf, 32'h1);
    for (int r = 0; r < 4; r++) begin
      wb(1, 8'h20, 4'hf, r); check("filter type", r, filter_type_o);
      sa = 0; sb = 0;
      for (int k = 0; k < (1 << r); k++) begin
        x = $urandom_range(24'h3fffff); y = $urandom_range(24'h3fffff); sa += x; sb += y; push(x, y);
      end
      pull(); check("dec left", sa >> r, ol); check("dec right", sb >> r, orr);
    end
    wb(1, 8'h20, 4'hf, 0);
    @(posedge clk_i); stall <= 1'b1;
    for (int k = 0; k < 4; k++) begin ql[k] = $urandom; qr[k] = $urandom; push(ql[k], qr[k]); end
    @(posedge clk_i); #1; check("fifo full", 0, in_ready_o);
    @(posedge clk_i); stall <= 1'b0;
    for (int k = 0; k < 4; k++) begin pull(); check("fifo order", {ql[k], qr[k]}, {ol, orr}); end
    wb(1, 8'h14, 4'hf, 32'h10);
    for (int k = 0; k < 24; k++) begin push(24'h010000, 24'h020000); pull(); end
    wb(0, 8'h28, 4'hf, 0); check("offset moves", 1, q[23:0] != 0 && ol < 24'h010000);
    wb(1, 8'h14, 4'hf, 32'h11); wb(0, 8'h28, 4'hf, 0); e = q; wb(0, 8'h2c, 4'hf, 0); e2 = q;
    for (int k = 0; k < 6; k++) begin
      x = $urandom_range(24'h3fffff); push(x, x); pull(); y = x - e[23:0]; check("held left", y, ol);
      y = x - e2[23:0]; check("held right", y, orr);
    end
    wb(0, 8'h28, 4'hf, 0); check("held estimate", e, q);
    wb(1, 8'h14, 4'hf, 32'h1); wb(0, 8'h28, 4'hf, 0); check("cleared estimate", 0, q);
    x = $urandom_range(24'h3fffff); push(x, x); pull(); check("no correction", x, ol);
    results();
  end
endmodule : igmdc_top_tb
